// *** design/pwr_clk_pkg.sv ***
// Constants shared by the power and clock-synthesiser control block.
// Assumes a 20 MHz system clock and APB with 32-bit data and 12-bit addresses.
package pwr_clk_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int LOCK_TIME_MS    = 10;
  localparam int LOCK_CYCLES     = LOCK_TIME_MS * (CLK_HZ / 1000);
  localparam int SETTLE_TIME_NS  = 1000;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map: printed offsets are word indices, byte address is four times
  localparam int              ADDR_W        = 12;
  localparam logic [ADDR_W-1:0] PWR_CTRL_IDX  = 12'h087;
  localparam logic [ADDR_W-1:0] CLK_SYNTH_IDX = 12'h0f9;
  localparam logic [ADDR_W-1:0] STATUS_IDX    = 12'h100;
  localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR  = ADDR_W'(PWR_CTRL_IDX * 4);
  localparam logic [ADDR_W-1:0] CLK_SYNTH_ADDR = ADDR_W'(CLK_SYNTH_IDX * 4);
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = ADDR_W'(STATUS_IDX * 4);

  localparam logic [7:0] PWR_CTRL_RST  = 8'h00;
  localparam logic [7:0] CLK_SYNTH_RST = 8'h0d;

  ////////////////////////////////////////////////////////////////////////////////
  // power_control fields
  localparam int PC_BAUD_DBL = 7;
  localparam int PC_AUX_OFF  = 6;
  localparam int PC_ALE_QUIET = 5;
  localparam int PC_WDT_UNLK = 4;
  localparam int PC_UFLAG_1  = 3;
  localparam int PC_UFLAG_0  = 2;
  localparam int PC_PD       = 1;
  localparam int PC_IDLE     = 0;

  // clock_synth_control fields
  localparam int CS_KEEP_SLOW = 7;
  localparam int CS_SEC_EN    = 6;
  localparam int CS_SEC_FLAG  = 5;
  localparam int CS_FREQ_SELECT_HI   = 4;
  localparam int CS_FREQ_SELECT_MID  = 2;
  localparam int CS_CCO_HI    = 1;
  localparam int CS_CCO_LO    = 0;

  // Status register fields
  localparam int ST_LOCKED   = 0;
  localparam int ST_SETTLED  = 1;
  localparam int ST_CODE_OK  = 2;
  localparam int ST_OSC_SEL  = 3;
  localparam int ST_WDT_EN   = 4;
  localparam int ST_IDLE     = 5;
  localparam int ST_PD       = 6;

  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PD   = 2'b10
  } power_mode_e;

  // System clock in units of 10 kHz; zero marks a reserved code
  function automatic logic [11:0] freq_10khz(input logic [4:0] code);
    case (code)
      5'h13:   freq_10khz = 12'h189;
      5'h0f:   freq_10khz = 12'h312;
      5'h0b:   freq_10khz = 12'h625;
      5'h12:   freq_10khz = 12'h1d8;
      5'h0e:   freq_10khz = 12'h3b0;
      5'h11:   freq_10khz = 12'h227;
      5'h0d:   freq_10khz = 12'h44d;
      5'h10:   freq_10khz = 12'h275;
      5'h0c:   freq_10khz = 12'h4ea;
      default: freq_10khz = 12'h000;
    endcase
  endfunction

endpackage

// *** design/settle_timer.sv ***
// One-shot down counter: busy stays high for CYCLES cycles after start.
// Assumes start is a same-clock signal; a start while busy restarts the count.
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int CYCLES = 20
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output var  logic busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      count <= CW'(CYCLES - 1);
      busy  <= 1'b1;
    end else if (count != '0) begin
      count <= count - CW'(1);
    end else begin
      busy <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** design/power_and_clock_synth_control.sv ***
// Power-mode and clock-source control with an APB register slave.
// Assumes a 20 MHz clk; pins are asynchronous, strobes from CPU logic are on clk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module power_and_clock_synth_control #(
  parameter int LOCK_CYCLES = pwr_clk_pkg::LOCK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Pins
  input  wire logic        osc_select_pin,
  input  wire logic        wdt_enable_input,
  input  wire logic        reset_input,
  input  wire logic        ext_irq_1,
  // Same-clock events and levels
  input  wire logic        wdt_overflow,
  input  wire logic        wdt_counter_loaded,
  input  wire logic        sec_tick,
  input  wire logic        wake_event,
  input  wire logic        ext_irq_1_enable,
  input  wire logic [1:0]  serial_mode,
  input  wire logic        ale_raw,
  // Controls out
  output var  logic        baud_double_active,
  output var  logic        aux_ram_enable,
  output var  logic        addr_latch_strobe,
  output var  logic        watchdog_load_unlock,
  output var  logic        idle_mode,
  output var  logic        power_down_mode,
  output var  logic        hf_osc_enable,
  output var  logic        slow_osc_enable,
  output var  logic        slow_osc_pull_low,
  output var  logic        pll_enable,
  output var  logic [1:0]  cco_band,
  output var  logic [4:0]  freq_code,
  output var  logic [11:0] sys_freq_10khz,
  output var  logic        pll_locked,
  output var  logic        clk_settled,
  output var  logic        shared_irq_1,
  output var  logic        sec_irq_to_cpu
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       osc_sel_s;
  logic       wdt_en_s;
  logic       rst_in_s;
  logic       irq1_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {ext_irq_1, reset_input, wdt_enable_input, osc_select_pin};
      pin_sync <= pin_meta;
    end
  end

  assign osc_sel_s = pin_sync[0];
  assign wdt_en_s  = pin_sync[1];
  assign rst_in_s  = pin_sync[2];
  assign irq1_s    = pin_sync[3];

  // Reset input and watchdog overflow both return the registers to reset values
  logic sys_clear;
  assign sys_clear = rst_in_s | wdt_overflow;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic       setup_phase;
  logic       access_done;
  logic       hit_pc;
  logic       hit_cs;
  logic       hit_st;
  logic       wr_pc;
  logic       wr_cs;
  logic [7:0] wbyte;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wbyte       = pwdata[7:0];

  always_comb begin
    hit_pc = 1'b0;
    hit_cs = 1'b0;
    hit_st = 1'b0;
    if (paddr == pwr_clk_pkg::PWR_CTRL_ADDR) begin
      hit_pc = 1'b1;
    end else if (paddr == pwr_clk_pkg::CLK_SYNTH_ADDR) begin
      hit_cs = 1'b1;
    end else if (paddr == pwr_clk_pkg::STATUS_ADDR) begin
      hit_st = 1'b1;
    end
  end

  // Whole-byte writes only; the register has no per-bit access path
  assign wr_pc = access_done & pwrite & hit_pc;
  assign wr_cs = access_done & pwrite & hit_cs;

  ////////////////////////////////////////////////////////////////////////////////
  // power_control

  logic [7:0] power_control;
  logic [7:0] next_power_control;

  always_comb begin
    next_power_control = power_control;
    if (wdt_counter_loaded) begin
      next_power_control[pwr_clk_pkg::PC_WDT_UNLK] = 1'b0;
    end
    if (wake_event) begin
      next_power_control[pwr_clk_pkg::PC_PD]   = 1'b0;
      next_power_control[pwr_clk_pkg::PC_IDLE] = 1'b0;
    end
    if (wr_pc) begin
      next_power_control = wbyte;
      // Power-down may only be set while the watchdog enable pin is high
      next_power_control[pwr_clk_pkg::PC_PD] = wbyte[pwr_clk_pkg::PC_PD] & wdt_en_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control <= pwr_clk_pkg::PWR_CTRL_RST;
    end else if (sys_clear) begin
      power_control <= pwr_clk_pkg::PWR_CTRL_RST;
    end else begin
      power_control <= next_power_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock_synth_control

  logic [7:0] clock_synth_control;
  logic [7:0] next_clock_synth_control;

  always_comb begin
    next_clock_synth_control = clock_synth_control;
    if (wr_cs) begin
      next_clock_synth_control = wbyte;
    end
    // A tick in the cycle of a clearing write still sets the flag
    if (sec_tick) begin
      next_clock_synth_control[pwr_clk_pkg::CS_SEC_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_synth_control <= pwr_clk_pkg::CLK_SYNTH_RST;
    end else if (sys_clear) begin
      clock_synth_control <= pwr_clk_pkg::CLK_SYNTH_RST;
    end else begin
      clock_synth_control <= next_clock_synth_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Loop lock and divider settle timing

  logic       band_change;
  logic       div_change;
  logic       lock_busy;
  logic       settle_busy;
  logic [1:0] cur_band;
  logic [2:0] cur_div;

  assign cur_band = clock_synth_control[pwr_clk_pkg::CS_CCO_HI:pwr_clk_pkg::CS_CCO_LO];
  assign cur_div  = clock_synth_control[pwr_clk_pkg::CS_FREQ_SELECT_HI:pwr_clk_pkg::CS_FREQ_SELECT_MID];

  // A band change relocks the loop; a divider-only change just settles
  assign band_change = sys_clear
                     | (wr_cs & (wbyte[pwr_clk_pkg::CS_CCO_HI:pwr_clk_pkg::CS_CCO_LO]
                                 != cur_band));
  assign div_change  = wr_cs & ~band_change
                     & (wbyte[pwr_clk_pkg::CS_FREQ_SELECT_HI:pwr_clk_pkg::CS_FREQ_SELECT_MID]
                        != cur_div);

  settle_timer #(
    .CYCLES (LOCK_CYCLES)
  ) u_lock_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (band_change),
    .busy  (lock_busy)
  );

  settle_timer #(
    .CYCLES (pwr_clk_pkg::SETTLE_CYCLES)
  ) u_div_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (div_change),
    .busy  (settle_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Power mode

  pwr_clk_pkg::power_mode_e mode;
  pwr_clk_pkg::power_mode_e next_mode;

  always_comb begin
    next_mode = pwr_clk_pkg::MODE_RUN;
    case ({next_power_control[pwr_clk_pkg::PC_PD], next_power_control[pwr_clk_pkg::PC_IDLE]})
      2'b10,
      2'b11: begin
        next_mode = pwr_clk_pkg::MODE_PD;
      end
      2'b01: begin
        next_mode = pwr_clk_pkg::MODE_IDLE;
      end
      default: begin
        next_mode = pwr_clk_pkg::MODE_RUN;
      end
    endcase
    if (sys_clear) begin
      next_mode = pwr_clk_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= pwr_clk_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator control

  logic in_pd;
  logic keep_slow;
  logic slow_run;

  assign in_pd     = (mode == pwr_clk_pkg::MODE_PD);
  assign keep_slow = clock_synth_control[pwr_clk_pkg::CS_KEEP_SLOW];
  assign slow_run  = ~osc_sel_s & ~rst_in_s & ~(in_pd & ~keep_slow);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hf_osc_enable     <= 1'b0;
      slow_osc_enable   <= 1'b0;
      slow_osc_pull_low <= 1'b1;
      pll_enable        <= 1'b0;
    end else begin
      hf_osc_enable     <= osc_sel_s & ~in_pd;
      slow_osc_enable   <= slow_run;
      slow_osc_pull_low <= ~slow_run;
      pll_enable        <= slow_run & ~in_pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency outputs

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cco_band       <= pwr_clk_pkg::CLK_SYNTH_RST[pwr_clk_pkg::CS_CCO_HI:pwr_clk_pkg::CS_CCO_LO];
      freq_code      <= pwr_clk_pkg::CLK_SYNTH_RST[pwr_clk_pkg::CS_FREQ_SELECT_HI:0];
      sys_freq_10khz <= pwr_clk_pkg::freq_10khz(pwr_clk_pkg::CLK_SYNTH_RST[pwr_clk_pkg::CS_FREQ_SELECT_HI:0]);
      pll_locked     <= 1'b0;
      clk_settled    <= 1'b0;
    end else begin
      cco_band       <= cur_band;
      freq_code      <= clock_synth_control[pwr_clk_pkg::CS_FREQ_SELECT_HI:0];
      sys_freq_10khz <= pwr_clk_pkg::freq_10khz(clock_synth_control[pwr_clk_pkg::CS_FREQ_SELECT_HI:0]);
      pll_locked     <= ~lock_busy & ~band_change;
      clk_settled    <= ~lock_busy & ~settle_busy & ~band_change & ~div_change;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial, memory and strobe controls

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_double_active   <= 1'b0;
      aux_ram_enable       <= 1'b1;
      addr_latch_strobe    <= 1'b0;
      watchdog_load_unlock <= 1'b0;
      idle_mode            <= 1'b0;
      power_down_mode      <= 1'b0;
    end else begin
      baud_double_active   <= power_control[pwr_clk_pkg::PC_BAUD_DBL]
                            & (serial_mode != 2'b00);
      aux_ram_enable       <= ~power_control[pwr_clk_pkg::PC_AUX_OFF];
      addr_latch_strobe    <= ale_raw & ~power_control[pwr_clk_pkg::PC_ALE_QUIET];
      watchdog_load_unlock <= power_control[pwr_clk_pkg::PC_WDT_UNLK];
      idle_mode            <= (mode == pwr_clk_pkg::MODE_IDLE);
      power_down_mode      <= in_pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Seconds interrupt

  logic sec_req;

  assign sec_req = clock_synth_control[pwr_clk_pkg::CS_SEC_FLAG]
                 & clock_synth_control[pwr_clk_pkg::CS_SEC_EN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_irq_1   <= 1'b0;
      sec_irq_to_cpu <= 1'b0;
    end else begin
      shared_irq_1   <= irq1_s | sec_req;
      sec_irq_to_cpu <= sec_req & ext_irq_1_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB answer: read data and error captured in the setup cycle

  logic [7:0] status;
  logic [7:0] rd_byte;

  always_comb begin
    status = 8'h00;
    status[pwr_clk_pkg::ST_LOCKED]  = pll_locked;
    status[pwr_clk_pkg::ST_SETTLED] = clk_settled;
    status[pwr_clk_pkg::ST_CODE_OK] = (sys_freq_10khz != 12'h000);
    status[pwr_clk_pkg::ST_OSC_SEL] = osc_sel_s;
    status[pwr_clk_pkg::ST_WDT_EN]  = wdt_en_s;
    status[pwr_clk_pkg::ST_IDLE]    = idle_mode;
    status[pwr_clk_pkg::ST_PD]      = power_down_mode;
    rd_byte = 8'h00;
    if (hit_pc) begin
      rd_byte = power_control;
    end else if (hit_cs) begin
      rd_byte = clock_synth_control;
    end else if (hit_st) begin
      rd_byte = status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~(hit_pc | hit_cs | hit_st);
      if (setup_phase & ~pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// *** dv/sec_source.sv ***
// Far-side model: seconds timer overflow and the CPU's address latch strobe.
// Assumes run is driven by the bench; ticks only while the slow oscillator runs.
`timescale 1ns/1ps
`default_nettype none
module sec_source #(
  parameter int TICK = 40
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic osc_on,
  output var  logic sec_tick,
  output var  logic ale_raw
);
  int cnt = 0;
  initial sec_tick = 1'h0;
  initial ale_raw = 1'h0;
  always @(posedge clk) begin
    ale_raw <= !ale_raw;
    sec_tick <= 1'h0;
    if (run && osc_on) begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      sec_tick <= (cnt == TICK - 1);
    end
  end
endmodule
`default_nettype wire

// *** dv/pwr_clk_props.sv ***
// Checker on the ports of the power and clock control block.
// Assumes it is bound to the block top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module pwr_clk_props #(
  parameter int LOCK_CYCLES = 50
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wdt_overflow,
  input wire logic [1:0]  serial_mode,
  input wire logic        ale_raw,
  input wire logic        ext_irq_1_enable,
  input wire logic        baud_double_active,
  input wire logic        addr_latch_strobe,
  input wire logic        hf_osc_enable,
  input wire logic        slow_osc_enable,
  input wire logic        slow_osc_pull_low,
  input wire logic        pll_enable,
  input wire logic [1:0]  cco_band,
  input wire logic [4:0]  freq_code,
  input wire logic        pll_locked,
  input wire logic        shared_irq_1,
  input wire logic        sec_irq_to_cpu
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ACCESS: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  AST_READ_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_ALE_LOW: assert property (addr_latch_strobe |-> $past(ale_raw))
    else $error("address latch strobe without cpu strobe");
  AST_SLOW_PULL: assert property (slow_osc_pull_low == !slow_osc_enable)
    else $error("slow oscillator pull-down wrong");
  AST_OSC_EXCL: assert property (!(hf_osc_enable && slow_osc_enable))
    else $error("both oscillators enabled");
  AST_PLL_SLOW: assert property (pll_enable |-> slow_osc_enable)
    else $error("loop enabled without slow oscillator");
  AST_BAUD_MODE: assert property (baud_double_active |-> $past(serial_mode) != 2'h0)
    else $error("baud doubling in serial mode 0");
  AST_IRQ_CPU: assert property (sec_irq_to_cpu |-> shared_irq_1 && $past(ext_irq_1_enable))
    else $error("seconds request without enable");
  AST_FREQ_OUT: assert property (psel && penable && pready && pwrite && !wdt_overflow
    && paddr == pwr_clk_pkg::CLK_SYNTH_ADDR |=> ##1 freq_code == $past(pwdata[4:0], 2))
    else $error("frequency code not taken from write");
  AST_BAND_LOCK: assert property ($changed(cco_band) |-> !pll_locked)
    else $error("lock kept over band change");
  CV_ERR: cover property (pready && pslverr);
  CV_CPU_IRQ: cover property ($rose(sec_irq_to_cpu));
  CV_LOCK: cover property ($rose(pll_locked));
endmodule

bind power_and_clock_synth_control pwr_clk_props #(.LOCK_CYCLES(LOCK_CYCLES)) props_i (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wdt_overflow(wdt_overflow), .serial_mode(serial_mode), .ale_raw(ale_raw),
  .ext_irq_1_enable(ext_irq_1_enable), .baud_double_active(baud_double_active),
  .addr_latch_strobe(addr_latch_strobe), .hf_osc_enable(hf_osc_enable),
  .slow_osc_enable(slow_osc_enable), .slow_osc_pull_low(slow_osc_pull_low),
  .pll_enable(pll_enable), .cco_band(cco_band), .freq_code(freq_code),
  .pll_locked(pll_locked), .shared_irq_1(shared_irq_1), .sec_irq_to_cpu(sec_irq_to_cpu));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the power and clock control block over APB.
// Assumes a shortened lock count; the seconds source model drives the tick.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LOCK = 50;
  localparam logic [11:0] PC = pwr_clk_pkg::PWR_CTRL_ADDR;
  localparam logic [11:0] CS = pwr_clk_pkg::CLK_SYNTH_ADDR;
  logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic osc_select_pin = 1'h1, wdt_enable_input = 1'h0, reset_input = 1'h0, ext_irq_1 = 1'h0;
  logic wdt_overflow = 1'h0, wdt_counter_loaded = 1'h0, wake_event = 1'h0, run = 1'h0;
  logic ext_irq_1_enable = 1'h0, er;
  logic [1:0] serial_mode = 2'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sec_tick, ale_raw, baud_double_active, aux_ram_enable;
  wire logic addr_latch_strobe, watchdog_load_unlock, idle_mode, power_down_mode;
  wire logic hf_osc_enable, slow_osc_enable, slow_osc_pull_low, pll_enable;
  wire logic pll_locked, clk_settled, shared_irq_1, sec_irq_to_cpu;
  wire logic [1:0] cco_band;
  wire logic [4:0] freq_code;
  wire logic [11:0] sys_freq_10khz;
  int err_total = 0, num_checks = 0, n;
  // Path of single-field steps so every change keeps the slow/fast ordering
  logic [4:0] codes [10] = '{5'h0c, 5'h10, 5'h11, 5'h12, 5'h13, 5'h0f, 5'h0b, 5'h0f, 5'h0e,
                              5'h0d};
  logic [11:0] f10k [10] = '{12'h4ea, 12'h275, 12'h227, 12'h1d8, 12'h189, 12'h312, 12'h625,
                              12'h312, 12'h3b0, 12'h44d};
  always #25 clk = ~clk;
  power_and_clock_synth_control #(.LOCK_CYCLES(LOCK)) power_and_clock_synth_control_i (.*);
  sec_source sec_source_i (.clk(clk), .run(run), .osc_on(slow_osc_enable),
    .sec_tick(sec_tick), .ale_raw(ale_raw));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits for pready at a rising edge; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= {24'ha5a5a5, d}; penable <= 1'h0;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h0);
    chk(nm, rd, exp);
  endtask
  task automatic look();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: wdt_counter_loaded <= 1'h1;
      1: wake_event <= 1'h1;
      default: wdt_overflow <= 1'h1;
    endcase
    @(posedge clk);
    {wdt_counter_loaded, wake_event, wdt_overflow} <= 3'h0;
  endtask
  // Counts cycles the selected status stays low after a write
  task automatic cntlow(input int s);
    int k;
    n = 0;
    for (k = 0; k < 400; k++) begin
      @(negedge clk);
      if ((s ? clk_settled : pll_locked) === 1'h0) n++;
      else if (n > 0) break;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc("pctl", PC, 32'h0);
    rdc("csyn", CS, 32'h0d);
    chk("aux", aux_ram_enable, 1'h1);
    chk("freq", sys_freq_10khz, 12'h44d);
    apb(1'h1, 12'h0, 8'hff);
    chk("werr", er, 1'h1);
    rdc("unmapped", 12'h0, 32'h0);
    chk("rerr", er, 1'h1);
  endtask
  task automatic t_pctl();
    apb(1'h1, PC, 8'hff);
    rdc("pd_refused", PC, 32'hfd);
    look();
    chk("aux", aux_ram_enable, 1'h0);
    chk("ale", addr_latch_strobe, 1'h0);
    chk("unlock", watchdog_load_unlock, 1'h1);
    chk("idle", idle_mode, 1'h1);
    chk("baud0", baud_double_active, 1'h0);
    @(posedge clk) serial_mode <= 2'h1;
    look();
    chk("baud1", baud_double_active, 1'h1);
    ev(0);
    rdc("unlock_clr", PC, 32'hed);
    ev(1);
    rdc("flags", PC, 32'hec);
    look();
    chk("idle_off", idle_mode, 1'h0);
    apb(1'h1, PC, 8'h00);
    look();
    chk("ale_run", addr_latch_strobe, !ale_raw);
    chk("baud_off", baud_double_active, 1'h0);
    @(posedge clk) wdt_enable_input <= 1'h1;
    look();
    apb(1'h1, PC, 8'h02);
    look();
    chk("pd", power_down_mode, 1'h1);
    chk("hf_pd", hf_osc_enable, 1'h0);
    ev(1);
  endtask
  task automatic t_osc();
    look();
    chk("hf", hf_osc_enable, 1'h1);
    chk("slow_hf", slow_osc_enable, 1'h0);
    chk("pull_hf", slow_osc_pull_low, 1'h1);
    @(posedge clk) osc_select_pin <= 1'h0;
    look();
    chk("hf_off", hf_osc_enable, 1'h0);
    chk("slow", slow_osc_enable, 1'h1);
    chk("pll", pll_enable, 1'h1);
    apb(1'h1, PC, 8'h02);
    look();
    chk("slow_pd", slow_osc_enable, 1'h0);
    apb(1'h1, CS, 8'h8d);
    look();
    chk("slow_keep", slow_osc_enable, 1'h1);
    chk("pll_pd", pll_enable, 1'h0);
    ev(1);
    @(posedge clk) reset_input <= 1'h1;
    look();
    chk("slow_rst", slow_osc_enable, 1'h0);
    rdc("csyn_rst", CS, 32'h0d);
    @(posedge clk) reset_input <= 1'h0;
    look();
    apb(1'h1, CS, 8'h8d);
    ev(2);
    rdc("csyn_wdt", CS, 32'h0d);
  endtask
  task automatic t_freq();
    int i;
    repeat (80) @(posedge clk);
    apb(1'h1, CS, 8'h0f);
    cntlow(0);
    chk("lock_len", n, LOCK + 1);
    apb(1'h1, CS, 8'h0b);
    cntlow(1);
    chk("settle_len", n, pwr_clk_pkg::SETTLE_CYCLES + 1);
    apb(1'h1, CS, 8'h0f);
    apb(1'h1, CS, 8'h0d);
    for (i = 0; i < 10; i++) begin
      apb(1'h1, CS, {3'h0, codes[i]});
      repeat (LOCK) @(posedge clk);
      look();
      chk("fclk", sys_freq_10khz, f10k[i]);
      apb(1'h0, pwr_clk_pkg::STATUS_ADDR, 8'h0);
      chk("code_ok", rd[2], 1'h1);
    end
    apb(1'h1, CS, 8'h1f);
    look();
    chk("fclk_res", sys_freq_10khz, 12'h0);
    rdc("res_kept", CS, 32'h1f);
    apb(1'h0, pwr_clk_pkg::STATUS_ADDR, 8'h0);
    chk("code_res", rd[2], 1'h0);
  endtask
  task automatic t_sec();
    apb(1'h1, CS, 8'h4d);
    @(posedge clk) run <= 1'h1;
    repeat (60) @(posedge clk);
    run <= 1'h0;
    rdc("tick_flag", CS, 32'h6d);
    look();
    chk("shared", shared_irq_1, 1'h1);
    chk("cpu_off", sec_irq_to_cpu, 1'h0);
    @(posedge clk) ext_irq_1_enable <= 1'h1;
    look();
    chk("cpu_on", sec_irq_to_cpu, 1'h1);
    apb(1'h1, CS, 8'h4d);
    rdc("flag_clr", CS, 32'h4d);
    look();
    chk("shared_clr", shared_irq_1, 1'h0);
    apb(1'h1, CS, 8'h6d);
    rdc("flag_sw", CS, 32'h6d);
    apb(1'h1, CS, 8'h2d);
    look();
    chk("shared_dis", shared_irq_1, 1'h0);
    chk("cpu_dis", sec_irq_to_cpu, 1'h0);
    @(posedge clk) ext_irq_1 <= 1'h1;
    look();
    chk("shared_pin", shared_irq_1, 1'h1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    t_reset();
    t_pctl();
    t_osc();
    t_freq();
    t_sec();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
